// ---- hdl/slcm_mode_check.sv ----
`timescale 1ns/1ps
`include "slcm_map.svh"
`default_nettype none

module slcm_mode_check
(
  input  wire logic                   [15:0] ctl_sel,
  input  wire logic                   [15:0] cyc_sel,
  input  wire logic                   [15:0] upd_ratio,
  input  wire logic                   [15:0] func_exp,
  input  wire slcm_pkg::slcm_mode_type       mode,
  output logic                               cfg_ok,
  output logic                               mode_ok
);

  logic semi;
  logic full;
  logic cyc_known;
  logic ratio_ok;
  logic fast_cyc;
  logic scale_block;

  always_comb
  begin
    semi        = (ctl_sel == `SLCM_CTL_SEMI);
    full        = (ctl_sel == `SLCM_CTL_FULL);
    cyc_known   = (cyc_sel == `SLCM_CYC_0833) || (cyc_sel == `SLCM_CYC_1666)
               || (cyc_sel == `SLCM_CYC_5000) || (cyc_sel == `SLCM_CYC_10000); // RULE3
    ratio_ok    = (upd_ratio == 16'h0001)
               || ((upd_ratio == 16'h0002)
               && ((cyc_sel == `SLCM_CYC_0833) || (cyc_sel == `SLCM_CYC_5000))); // RULE4 RULE5
    cfg_ok      = (semi || full) && cyc_known && ratio_ok; // RULE6
    fast_cyc    = (cyc_sel == `SLCM_CYC_0833) || (cyc_sel == `SLCM_CYC_1666);
    scale_block = semi && func_exp[`SLCM_FX_SCALE_MON] && fast_cyc; // RULE11
    case (mode)
      slcm_pkg::no_operation_mode:
      begin
        mode_ok = 1'b1;
      end
      slcm_pkg::profile_position_mode,
      slcm_pkg::cyclic_position_mode:
      begin
        mode_ok = (semi || full) && !scale_block; // RULE1 RULE2
      end
      slcm_pkg::cyclic_velocity_mode,
      slcm_pkg::cyclic_torque_mode:
      begin
        mode_ok = semi && !scale_block; // RULE1 RULE2
      end
      default:
      begin
        mode_ok = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- hdl/slcm_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none

module slcm_sync3
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_out
);

  slcm_pkg::slcm_sync_state_type q;
  slcm_pkg::slcm_sync_state_type d;

  always_comb
  begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3)
    begin
      d.val = q.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign level_out = q.val;

endmodule

`default_nettype wire

// ---- hdl/slcm_top.sv ----
// Contract
// RULE1: Semi-closed control (code 0) allows profile, cyclic position, velocity and torque.
// RULE2: Full-closed control (selector 6) accepts only profile and cyclic position modes.
// RULE3: Cycle code 0 is 0.0833 ms, 1 is 0.1666 ms, 3 is 0.5 ms, 6 is 1.0 ms; others reserved.
// RULE4: The update ratio 1 or 2 makes the command update cycle that many communication cycles.
// RULE5: A ratio of 2 is valid only with a 0.0833 ms or 0.5 ms communication cycle.
// RULE6: An unsupported cycle and ratio pair raises parameter setup error code 93.5.
// RULE7: Function expansion bit 0 selects 16-byte frames when 0 and 32-byte frames when 1.
// RULE8: Bit 1 picks semi or full inter-axis sync with the timing counter flag, else is 0.
// RULE9: Software writes zero to function expansion bits 2 and 3.
// RULE10: Bit 4 enables scale monitoring in semi-closed control; full-closed always monitors.
// RULE11: Semi-closed scale monitoring forbids cycles of 0.1666 ms or less except no-operation.
// RULE12: The host uses the same cycle, ratio and expansion settings as the device.
// RULE13: Under semi-closed control the host picks the mode by the command code of each frame.
// RULE14: Code nibble 0 no-op, 1 profile, 2 cyclic position, 3 velocity, 4 torque; no-op holds.
// RULE15: Checks run before the link leaves its initial state; an error holds until reset.
`timescale 1ns/1ps
`include "slcm_map.svh"
`default_nettype none

module slcm_top
#(
  parameter int CYC0_CLKS = `SLCM_T0833_NS / `SLCM_CLK_NS,
  parameter int CYC1_CLKS = `SLCM_T1666_NS / `SLCM_CLK_NS,
  parameter int CYC3_CLKS = `SLCM_T5000_NS / `SLCM_CLK_NS,
  parameter int CYC6_CLKS = `SLCM_T10000_NS / `SLCM_CLK_NS
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        link_start_pin,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        timing_counter_flag,
  output logic             link_run,
  output logic             param_error,
  output logic      [2:0]  active_mode,
  output logic             cmd_reject,
  output logic             frame_32byte,
  output logic             full_sync_mode,
  output logic             scale_monitor,
  output logic             comm_tick,
  output logic             cmd_update_tick
);

  localparam int CNT_MAX = 1 << 20;

  if (CYC0_CLKS < 1 || CYC1_CLKS < 1 || CYC3_CLKS < 1 || CYC6_CLKS < 1)
  begin : g_chk_lo
    $error("Cycle counts must be at least one clock");
  end
  if (CYC0_CLKS > CNT_MAX || CYC1_CLKS > CNT_MAX
      || CYC3_CLKS > CNT_MAX || CYC6_CLKS > CNT_MAX)
  begin : g_chk_hi
    $error("Cycle counts exceed the counter width");
  end

  slcm_pkg::slcm_top_state_type q;
  slcm_pkg::slcm_top_state_type d;

  logic                    link_start;
  logic                    cfg_ok;
  logic                    mode_ok;
  slcm_pkg::slcm_mode_type cmd_mode;
  logic                    nibble_ok;
  logic [19:0]             period_m1;
  logic [31:0]             status_word;

  slcm_sync3 u_sync
  (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_in    (link_start_pin),
    .level_out (link_start)
  );

  // Checks against the stored settings
  slcm_mode_check u_cfg
  (
    .ctl_sel   (q.ctl),
    .cyc_sel   (q.cyc),
    .upd_ratio (q.ratio),
    .func_exp  (q.fexp),
    .mode      (slcm_pkg::no_operation_mode),
    .cfg_ok    (cfg_ok),
    .mode_ok   ()
  );

  // Checks of the incoming command mode
  slcm_mode_check u_mode
  (
    .ctl_sel   (q.ctl),
    .cyc_sel   (q.cyc),
    .upd_ratio (q.ratio),
    .func_exp  (q.fexp),
    .mode      (cmd_mode),
    .cfg_ok    (),
    .mode_ok   (mode_ok)
  );

  always_comb
  begin
    nibble_ok = (cmd_code[7:4] <= 4'h4); // RULE14
    if (nibble_ok)
    begin
      cmd_mode = slcm_pkg::slcm_mode_type'(cmd_code[6:4]);
    end
    else
    begin
      cmd_mode = slcm_pkg::no_operation_mode;
    end
  end

  // Communication cycle length in clocks, minus one
  always_comb
  begin
    case (q.cyc)
      `SLCM_CYC_0833:
      begin
        period_m1 = 20'(CYC0_CLKS - 1); // RULE3
      end
      `SLCM_CYC_1666:
      begin
        period_m1 = 20'(CYC1_CLKS - 1); // RULE3
      end
      `SLCM_CYC_5000:
      begin
        period_m1 = 20'(CYC3_CLKS - 1); // RULE3
      end
      default:
      begin
        period_m1 = 20'(CYC6_CLKS - 1); // RULE3
      end
    endcase
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`SLCM_ST_RUN] = q.st == slcm_pkg::SLCM_RUN;
    status_word[`SLCM_ST_ERR] = q.cfg_err;
    status_word[`SLCM_ST_FRAME32] = q.frame32;
    status_word[`SLCM_ST_FULL_SYNC] = q.full_sync;
    status_word[`SLCM_ST_SCALE_MON] = q.scale_mon;
    status_word[`SLCM_ST_MODE_LSB +: 3] = q.mode;
    if (q.cfg_err)
    begin
      status_word[`SLCM_ST_CODE_LSB +: 12] = {`SLCM_ERR_MAIN, `SLCM_ERR_SUB}; // RULE6
    end
  end

  always_comb
  begin
    d = q;
    d.reject = 1'b0;
    d.comm_tick = 1'b0;
    d.upd_tick = 1'b0;
    d.rdata = 32'h0000_0000;

    // Settings change only while the link is idle
    if (reg_wr && q.st == slcm_pkg::SLCM_INIT)
    begin
      case (reg_addr)
        `SLCM_OFS_CTL_SEL:
        begin
          d.ctl = reg_wdata[15:0];
        end
        `SLCM_OFS_CYC_SEL:
        begin
          d.cyc = reg_wdata[15:0];
        end
        `SLCM_OFS_UPD_RATIO:
        begin
          d.ratio = reg_wdata[15:0];
        end
        `SLCM_OFS_FUNC_EXP:
        begin
          d.fexp = reg_wdata[15:0];
        end
        default:
        begin
          d.fexp = q.fexp;
        end
      endcase
    end

    if (reg_rd)
    begin
      case (reg_addr)
        `SLCM_OFS_CTL_SEL:
        begin
          d.rdata = {16'h0000, q.ctl};
        end
        `SLCM_OFS_CYC_SEL:
        begin
          d.rdata = {16'h0000, q.cyc};
        end
        `SLCM_OFS_UPD_RATIO:
        begin
          d.rdata = {16'h0000, q.ratio};
        end
        `SLCM_OFS_FUNC_EXP:
        begin
          d.rdata = {16'h0000, q.fexp};
        end
        `SLCM_OFS_STATUS:
        begin
          d.rdata = status_word;
        end
        default:
        begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end

    d.frame32 = q.fexp[`SLCM_FX_FRAME32]; // RULE7
    d.full_sync = q.fexp[`SLCM_FX_FULL_SYNC] && timing_counter_flag; // RULE8
    d.scale_mon = (q.ctl == `SLCM_CTL_FULL)
               || ((q.ctl == `SLCM_CTL_SEMI) && q.fexp[`SLCM_FX_SCALE_MON]); // RULE10

    case (q.st)
      slcm_pkg::SLCM_INIT:
      begin
        d.cnt = 20'h0_0000;
        d.upd = 2'h0;
        if (link_start)
        begin
          if (cfg_ok)
          begin
            d.st = slcm_pkg::SLCM_RUN; // RULE15
          end
          else
          begin
            d.st = slcm_pkg::SLCM_FAULT; // RULE15
            d.cfg_err = 1'b1; // RULE6
          end
        end
      end
      slcm_pkg::SLCM_RUN:
      begin
        if (!link_start)
        begin
          d.st = slcm_pkg::SLCM_INIT;
        end
        if (q.cnt == period_m1)
        begin
          d.cnt = 20'h0_0000;
          d.comm_tick = 1'b1;
          if (q.upd + 2'h1 >= q.ratio[1:0])
          begin
            d.upd = 2'h0;
            d.upd_tick = 1'b1; // RULE4
          end
          else
          begin
            d.upd = q.upd + 2'h1;
          end
        end
        else
        begin
          d.cnt = q.cnt + 20'h0_0001;
        end
        if (cmd_valid)
        begin
          if (!nibble_ok || !mode_ok)
          begin
            d.reject = 1'b1; // RULE1 RULE2 RULE11
          end
          else if (cmd_mode != slcm_pkg::no_operation_mode)
          begin
            d.mode = cmd_mode; // RULE14
          end
        end
      end
      slcm_pkg::SLCM_FAULT:
      begin
        d.cfg_err = 1'b1; // RULE15
      end
      default:
      begin
        d.st = slcm_pkg::SLCM_INIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '{st: slcm_pkg::SLCM_INIT,
             ctl: `SLCM_RST_CTL_SEL,
             cyc: `SLCM_RST_CYC_SEL,
             ratio: `SLCM_RST_UPD_RATIO,
             fexp: `SLCM_RST_FUNC_EXP,
             mode: slcm_pkg::no_operation_mode,
             default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata       = q.rdata;
  assign link_run        = q.st[1];
  assign param_error     = q.cfg_err;
  assign active_mode     = q.mode;
  assign cmd_reject      = q.reject;
  assign frame_32byte    = q.frame32;
  assign full_sync_mode  = q.full_sync;
  assign scale_monitor   = q.scale_mon;
  assign comm_tick       = q.comm_tick;
  assign cmd_update_tick = q.upd_tick;

endmodule

`default_nettype wire

// ---- shared/slcm_map.svh ----
`ifndef SLCM_MAP_SVH
`define SLCM_MAP_SVH

// Register byte offsets
`define SLCM_OFS_CTL_SEL      8'h00
`define SLCM_OFS_CYC_SEL      8'h04
`define SLCM_OFS_UPD_RATIO    8'h08
`define SLCM_OFS_FUNC_EXP     8'h0C
`define SLCM_OFS_STATUS       8'h10

// Reset values
`define SLCM_RST_CTL_SEL      16'h0000
`define SLCM_RST_CYC_SEL      16'h0003
`define SLCM_RST_UPD_RATIO    16'h0001
`define SLCM_RST_FUNC_EXP     16'h0000

// Control system codes
`define SLCM_CTL_SEMI         16'h0000
`define SLCM_CTL_FULL         16'h0006

// Communication cycle codes
`define SLCM_CYC_0833         16'h0000
`define SLCM_CYC_1666         16'h0001
`define SLCM_CYC_5000         16'h0003
`define SLCM_CYC_10000        16'h0006

// Function expansion field positions
`define SLCM_FX_FRAME32       0
`define SLCM_FX_FULL_SYNC     1
`define SLCM_FX_SCALE_MON     4

// Status field positions
`define SLCM_ST_RUN           0
`define SLCM_ST_ERR           1
`define SLCM_ST_FRAME32       2
`define SLCM_ST_FULL_SYNC     3
`define SLCM_ST_SCALE_MON     4
`define SLCM_ST_MODE_LSB      5
`define SLCM_ST_CODE_LSB      8

// Parameter setup error code 93.5
`define SLCM_ERR_MAIN         8'h5D
`define SLCM_ERR_SUB          4'h5

// Timing in ns
`define SLCM_CLK_NS           4
`define SLCM_T0833_NS         83300
`define SLCM_T1666_NS         166600
`define SLCM_T5000_NS         500000
`define SLCM_T10000_NS        1000000

`endif

// ---- shared/slcm_pkg.sv ----
package slcm_pkg;

  typedef enum logic [2:0]
  {
    SLCM_INIT  = 3'b001,
    SLCM_RUN   = 3'b010,
    SLCM_FAULT = 3'b100
  } slcm_state_type;

  typedef enum logic [2:0]
  {
    no_operation_mode     = 3'h0,
    profile_position_mode = 3'h1,
    cyclic_position_mode  = 3'h2,
    cyclic_velocity_mode  = 3'h3,
    cyclic_torque_mode    = 3'h4
  } slcm_mode_type;

  typedef struct packed
  {
    slcm_state_type st;
    logic [15:0]    ctl;
    logic [15:0]    cyc;
    logic [15:0]    ratio;
    logic [15:0]    fexp;
    logic [31:0]    rdata;
    logic           cfg_err;
    slcm_mode_type  mode;
    logic           reject;
    logic [19:0]    cnt;
    logic [1:0]     upd;
    logic           comm_tick;
    logic           upd_tick;
    logic           frame32;
    logic           full_sync;
    logic           scale_mon;
  } slcm_top_state_type;

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } slcm_sync_state_type;

endpackage

// ---- tb/servo_link_cycle_mode_config_bench.sv ----
`timescale 1ns/1ps
`include "slcm_map.svh"
`default_nettype none

module servo_link_cycle_mode_config_bench;
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        pin;
  logic        send_req;
  logic [7:0]  send_code;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic        tflag;
  logic        link_run;
  logic        param_error;
  logic [2:0]  active_mode;
  logic        cmd_reject;
  logic        frame_32byte;
  logic        full_sync_mode;
  logic        scale_monitor;
  logic        comm_tick;
  logic        cmd_update_tick;
  logic [31:0] rd;
  int          n_errors;
  int          total_checks;

  slcm_top #(.CYC0_CLKS(5), .CYC1_CLKS(10), .CYC3_CLKS(30), .CYC6_CLKS(60)) slcm_top_inst
  (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_start_pin(pin), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .timing_counter_flag(tflag), .link_run(link_run),
    .param_error(param_error), .active_mode(active_mode), .cmd_reject(cmd_reject),
    .frame_32byte(frame_32byte), .full_sync_mode(full_sync_mode),
    .scale_monitor(scale_monitor), .comm_tick(comm_tick), .cmd_update_tick(cmd_update_tick)
  );

  slcm_host_model slcm_host_model_inst
  (
    .clk(clk), .rst_b(rst_b), .send_req(send_req), .send_code(send_code),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic restart(input logic [15:0] ctl, input logic [15:0] cyc,
                         input logic [15:0] ratio, input logic [15:0] fx);
    @(posedge clk);
    rst_b <= 1'b0;
    pin   <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wr(`SLCM_OFS_CTL_SEL, {16'h0000, ctl});
    wr(`SLCM_OFS_CYC_SEL, {16'h0000, cyc});
    wr(`SLCM_OFS_UPD_RATIO, {16'h0000, ratio});
    wr(`SLCM_OFS_FUNC_EXP, {16'h0000, fx[15:4], 2'b00, fx[1:0]});
    @(posedge clk);
    pin <= 1'b1;
    for (int i = 0; i < 20 && link_run !== 1'b1 && param_error !== 1'b1; i++)
      step();
    step();
  endtask

  task automatic cmd(input logic [7:0] code, input logic [2:0] mode, input logic rej);
    @(posedge clk);
    send_req  <= 1'b1;
    send_code <= code;
    @(posedge clk);
    send_req <= 1'b0;
    step();
    check(32'(active_mode), 32'(mode));
    check(32'(cmd_reject), 32'(rej));
  endtask

  task automatic ticks(input int period, input int ratio);
    int n;
    int c;
    n = 0;
    while (comm_tick !== 1'b1 && n < 200)
    begin
      step();
      n++;
    end
    n = 0;
    do
    begin
      step();
      n++;
    end
    while (comm_tick !== 1'b1 && n < 200);
    check(n, period);
    n = 0;
    while (cmd_update_tick !== 1'b1 && n < 400)
    begin
      step();
      n++;
    end
    c = 0;
    do
    begin
      step();
      n++;
      if (comm_tick === 1'b1)
        c++;
    end
    while (cmd_update_tick !== 1'b1 && n < 400);
    check(c, ratio);
  endtask

  task automatic t_semi();
    @(posedge clk);
    tflag <= 1'b1;
    restart(`SLCM_CTL_SEMI, `SLCM_CYC_5000, 16'h0002, 16'h0003);
    check(32'(link_run), 32'h0000_0001);
    check(32'(frame_32byte), 32'h0000_0001);
    check(32'(full_sync_mode), 32'h0000_0001);
    check(32'(scale_monitor), 32'h0000_0000);
    for (int m = 1; m <= 4; m++)
      cmd({m[3:0], 4'h0}, m[2:0], 1'b0);
    cmd(8'h05, 3'h4, 1'b0);
    cmd(8'h50, 3'h4, 1'b1);
    ticks(30, 2);
    wr(`SLCM_OFS_CYC_SEL, 32'h0000_0006);
    rdr(`SLCM_OFS_CYC_SEL);
    check(rd, 32'h0000_0003);
    @(posedge clk);
    pin <= 1'b0;
    repeat (10) step();
    check(32'(link_run), 32'h0000_0000);
    $display("semi-closed modes done");
  endtask

  task automatic t_full();
    @(posedge clk);
    tflag <= 1'b0;
    restart(`SLCM_CTL_FULL, `SLCM_CYC_10000, 16'h0001, 16'h0000);
    check(32'(frame_32byte), 32'h0000_0000);
    check(32'(full_sync_mode), 32'h0000_0000);
    check(32'(scale_monitor), 32'h0000_0001);
    cmd(8'h20, 3'h2, 1'b0);
    cmd(8'h30, 3'h2, 1'b1);
    cmd(8'h40, 3'h2, 1'b1);
    cmd(8'h10, 3'h1, 1'b0);
    ticks(60, 1);
    $display("full-closed modes done");
  endtask

  task automatic t_scale();
    restart(`SLCM_CTL_SEMI, `SLCM_CYC_0833, 16'h0002, 16'h0010);
    check(32'(param_error), 32'h0000_0000);
    check(32'(scale_monitor), 32'h0000_0001);
    cmd(8'h20, 3'h0, 1'b1);
    cmd(8'h00, 3'h0, 1'b0);
    $display("scale monitor limits done");
  endtask

  task automatic t_bad();
    logic [15:0] cy [3] = '{16'h0001, 16'h0006, 16'h0002};
    logic [15:0] ra [3] = '{16'h0002, 16'h0002, 16'h0001};
    for (int k = 0; k < 3; k++)
    begin
      restart(`SLCM_CTL_SEMI, cy[k], ra[k], 16'h0000);
      check(32'(param_error), 32'h0000_0001);
      rdr(`SLCM_OFS_STATUS);
      check(32'(rd[19:8]), 32'h0000_05D5);
      @(posedge clk);
      pin <= 1'b0;
      repeat (10) step();
      check(32'(param_error), 32'h0000_0001);
    end
    $display("bad cycle pairs done");
  endtask

  task automatic t_regs();
    logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
    logic [31:0] exp [5] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0001,
                             32'h0000_0000, 32'h0000_0000};
    restart(`SLCM_CTL_FULL, `SLCM_CYC_0833, 16'h0002, 16'h0011);
    @(posedge clk);
    rst_b <= 1'b0;
    pin   <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      rdr(ofs[k]);
      check(rd, exp[k]);
    end
    wr(`SLCM_OFS_STATUS, 32'h0000_FFFF);
    rdr(`SLCM_OFS_STATUS);
    check(rd, 32'h0000_0000);
    $display("register defaults done");
  endtask

  initial
  begin
    rst_b     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    pin       = 1'b0;
    send_req  = 1'b0;
    send_code = 8'h00;
    tflag     = 1'b0;
    n_errors  = 0;
    total_checks = 0;
    t_regs();
    t_semi();
    t_full();
    t_scale();
    t_bad();
    report_and_stop();
  end

  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire

// ---- tb/slcm_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module slcm_host_model
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       send_req,
  input  wire logic [7:0] send_code,
  output logic            cmd_valid,
  output logic      [7:0] cmd_code
);
  // One frame per request; the code lines toggle between frames
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_valid <= 1'b0;
      cmd_code  <= 8'h00;
    end
    else
    begin
      cmd_valid <= send_req;
      cmd_code  <= send_req ? send_code : ~cmd_code;
    end
  end
endmodule

`default_nettype wire

// ---- tb/slcm_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module slcm_top_sva
#(
  parameter int CYC0_CLKS = 5,
  parameter int CYC1_CLKS = 10,
  parameter int CYC3_CLKS = 30,
  parameter int CYC6_CLKS = 60
)
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        timing_counter_flag,
  input wire logic        link_run,
  input wire logic        param_error,
  input wire logic [2:0]  active_mode,
  input wire logic        cmd_reject,
  input wire logic        frame_32byte,
  input wire logic        full_sync_mode,
  input wire logic        comm_tick,
  input wire logic        cmd_update_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence fexp_write;
    reg_wr && reg_addr == 8'h0C && !link_run && !param_error;
  endsequence
  sequence cmd_taken;
    cmd_valid && link_run;
  endsequence

  err_sticky_a: assert property (param_error |=> param_error)
    else $error("setup error dropped before reset");
  err_from_init_a: assert property ($rose(param_error) |-> $past(!link_run))
    else $error("setup error raised after link left initial state");
  run_err_excl_a: assert property (!(link_run && param_error))
    else $error("link running with setup error");
  frame_size_a: assert property (fexp_write |->
    ##2 frame_32byte == $past(reg_wdata[0], 2))
    else $error("frame size not following expansion bit 0");
  sync_flag_a: assert property (full_sync_mode |-> $past(timing_counter_flag))
    else $error("full sync without timing counter flag");
  tick_pulse_a: assert property (comm_tick |=> !comm_tick [*3])
    else $error("communication tick too close");
  upd_on_tick_a: assert property (cmd_update_tick |-> comm_tick)
    else $error("update tick off a communication tick");
  nop_keep_a: assert property (cmd_taken and cmd_code[7:4] == 4'h0
    |=> $stable(active_mode) && !cmd_reject)
    else $error("no-operation changed the mode");
  bad_code_a: assert property (cmd_taken and cmd_code[7:4] > 4'h4 |=> cmd_reject)
    else $error("unknown mode code not refused");
  mode_cause_a: assert property ($changed(active_mode) && link_run |-> $past(cmd_valid))
    else $error("mode changed without a command");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read answer");
endmodule

bind slcm_top slcm_top_sva #(.CYC0_CLKS(CYC0_CLKS), .CYC1_CLKS(CYC1_CLKS),
  .CYC3_CLKS(CYC3_CLKS), .CYC6_CLKS(CYC6_CLKS)) slcm_top_sva_inst
(
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .timing_counter_flag(timing_counter_flag), .link_run(link_run),
  .param_error(param_error), .active_mode(active_mode), .cmd_reject(cmd_reject),
  .frame_32byte(frame_32byte), .full_sync_mode(full_sync_mode), .comm_tick(comm_tick),
  .cmd_update_tick(cmd_update_tick)
);

`default_nettype wire
